// *** rtl/adc_config_register_bank.sv ***
// serial-port configuration register bank of a data converter
// assumes serial pins are asynchronous and sampled by a 20 MHz clk
//
// Summary of operation
// [R01] writing one to the soft reset bit clears all registers; bit never stored
// [R02] control bit zero picks overrange or register readback on shared pin
// [R03] register one bits 7..2 hold the output swing code
// [R04] swing code applies only while either swing enable bit 1..0 of 0x43 is set
// [R05] one write updates every field of a register together
// [R06] every register reads zero after pin reset or soft reset
// [R07] controller writes zeros to reserved bits
// [R08] custom pattern bits 10..3 in 0x3F, bits 2..0 in 0x40 top bits
// [R09] 0xCF holds hold bit, time constant field, reserved low bits
// [R10] select low: bit in per falling serial clock, write every sixteenth
// [R11] word is eight address bits then eight data bits, many per frame
// [R12] in readback mode only register zero accepts writes, reads zero
// [R13] readback returns stored bits with reserved bits zero
`timescale 1ns/1ps
module adc_config_register_bank
   import cfg_bank_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hw_reset,
   input wire logic sclk,
   input wire logic serial_select_n,
   input wire logic serial_data_in,
   input wire logic overrange_in,
   output logic overrange_or_readback_pin,
   output logic readback_mode,
   output logic [SWING_W-1:0] swing_code,
   output logic [10:0] custom_pattern,
   output logic [7:0] gain_and_test_pattern,
   output logic [7:0] output_drive_strength,
   output logic [7:0] format_offset_noise_shaping,
   output logic [7:0] noise_shaping_coefficient_two,
   output logic [7:0] interface_and_clock_rise_control,
   output logic [7:0] clock_fall_latency_standby,
   output logic [7:0] power_down_and_swing_enable,
   output logic [7:0] offset_add_value,
   output logic [7:0] offset_correction_control,
   output logic [7:0] low_speed_mode,
   output logic [7:0] noise_shaping_pin_override
);
   logic sclk_f;
   logic sel_n_f;
   logic sdi_f;
   logic hw_rst_f;
   logic sclk_prev_q, sclk_prev_d;
   logic [3:0] bit_cnt_q, bit_cnt_d;
   logic [14:0] shift_q, shift_d;
   logic [7:0] out_sr_q, out_sr_d;
   logic pin_q, pin_d;
   logic [SWING_W-1:0] swing_q;
   logic [SWING_W-1:0] swing_d;
   logic [7:0] regs_q [NUM_REGS];
   logic [7:0] regs_d [NUM_REGS];
   logic fall;
   logic [7:0] addr_now;
   logic [7:0] word_addr;
   logic [7:0] word_data;
   logic [7:0] rd_val;

   // serial and reset pin filters
   pin_filter #(.RESET_LEVEL(1'b0)) u_sclk
   (
      .clk(clk),
      .rst_b(rst_b),
      .pin(sclk),
      .level(sclk_f)
   );
   pin_filter #(.RESET_LEVEL(1'b1)) u_sel
   (
      .clk(clk),
      .rst_b(rst_b),
      .pin(serial_select_n),
      .level(sel_n_f)
   );
   pin_filter #(.RESET_LEVEL(1'b0)) u_sdi
   (
      .clk(clk),
      .rst_b(rst_b),
      .pin(serial_data_in),
      .level(sdi_f)
   );
   pin_filter #(.RESET_LEVEL(1'b0)) u_hwr
   (
      .clk(clk),
      .rst_b(rst_b),
      .pin(hw_reset),
      .level(hw_rst_f)
   );

   assign fall = sclk_prev_q & ~sclk_f;
   assign addr_now = {shift_q[6:0], sdi_f};
   assign word_addr = shift_q[14:7];
   assign word_data = {shift_q[6:0], sdi_f};

   // address lookup for readback
   always_comb
   begin
      rd_val = RST_VAL;
      for (int i = 1; i < NUM_REGS; i++)
      begin
         if (REG_ADDR[i] == addr_now)
         begin
            rd_val = regs_q[i] & REG_MASK[i]; // [R13]
         end
      end
      // register zero never reads back
      if (addr_now == ADDR_RESET_AND_READBACK_CONTROL)
      begin
         rd_val = RST_VAL; // [R12]
      end
   end

   // shift, readout load and register commit
   always_comb
   begin
      sclk_prev_d = sclk_f;
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      out_sr_d = out_sr_q;
      regs_d = regs_q;
      if (sel_n_f)
      begin
         // frame end drops any partial word
         bit_cnt_d = 4'h0; // [R10]
      end
      else if (fall)
      begin
         shift_d = {shift_q[13:0], sdi_f}; // [R10]
         bit_cnt_d = bit_cnt_q + 4'h1; // [R11]
         if (bit_cnt_q == CNT_ADDR_DONE)
         begin
            out_sr_d = rd_val; // [R13]
         end
         else
         begin
            out_sr_d = {out_sr_q[6:0], 1'b0};
         end
         if (bit_cnt_q == CNT_WORD_DONE)
         begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
               if (REG_ADDR[i] == word_addr &&
                   (!regs_q[IDX_CTRL][READBACK_BIT] || i == IDX_CTRL)) // [R12]
               begin
                  regs_d[i] = word_data & REG_MASK[i]; // [R05] [R07] [R08] [R09]
               end
            end
            if (word_addr == ADDR_RESET_AND_READBACK_CONTROL &&
                word_data[SOFT_RESET_BIT])
            begin
               for (int i = 0; i < NUM_REGS; i++)
               begin
                  regs_d[i] = RST_VAL; // [R01] [R06]
               end
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b || hw_rst_f)
      begin
         sclk_prev_q <= 1'b0;
         bit_cnt_q <= 4'h0;
         shift_q <= 15'h0000;
         out_sr_q <= RST_VAL;
         for (int i = 0; i < NUM_REGS; i++)
         begin
            regs_q[i] <= RST_VAL; // [R06]
         end
      end
      else
      begin
         sclk_prev_q <= sclk_prev_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         out_sr_q <= out_sr_d;
         regs_q <= regs_d;
      end
   end

   // shared pin role from current register state, gated swing from next register state
   always_comb
   begin
      pin_d = regs_q[IDX_CTRL][READBACK_BIT] ? out_sr_q[7] : overrange_in; // [R02]
      swing_d = SWING_DEFAULT;
      if (regs_d[IDX_PWR][1:0] != SWING_EN_OFF) // [R04]
      begin
         swing_d = regs_d[IDX_SWING][SWING_LSB +: SWING_W]; // [R03]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b || hw_rst_f)
      begin
         pin_q <= 1'b0;
         swing_q <= SWING_DEFAULT;
      end
      else
      begin
         pin_q <= pin_d;
         swing_q <= swing_d;
      end
   end

   assign overrange_or_readback_pin = pin_q;
   assign readback_mode = regs_q[IDX_CTRL][READBACK_BIT];
   assign swing_code = swing_q; // [R03] [R04]
   // output taps of the register array
   assign custom_pattern = {regs_q[6], regs_q[7][7:5]}; // [R08]
   assign gain_and_test_pattern = regs_q[2];
   assign output_drive_strength = regs_q[3];
   assign format_offset_noise_shaping = regs_q[4];
   assign noise_shaping_coefficient_two = regs_q[5];
   assign interface_and_clock_rise_control = regs_q[8];
   assign clock_fall_latency_standby = regs_q[9];
   assign power_down_and_swing_enable = regs_q[10];
   assign offset_add_value = regs_q[11];
   assign offset_correction_control = regs_q[12]; // [R09]
   assign low_speed_mode = regs_q[13];
   assign noise_shaping_pin_override = regs_q[14];
endmodule : adc_config_register_bank

// *** rtl/cfg_bank_pkg.sv ***
// constants for the serial configuration register bank
// assumes one 20 MHz system clock samples all serial pins
package cfg_bank_pkg;
   localparam int NUM_REGS = 15;
   localparam int WORD_BITS = 16;
   localparam int CLK_MHZ = 20;
   localparam logic [7:0] RST_VAL = 8'h00;
   localparam logic [3:0] CNT_ADDR_DONE = 4'h7;
   localparam logic [3:0] CNT_WORD_DONE = 4'hF;
   // register offsets
   localparam logic [7:0] ADDR_RESET_AND_READBACK_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_OUTPUT_SWING_SELECT = 8'h01;
   localparam logic [7:0] ADDR_GAIN_AND_TEST_PATTERN = 8'h25;
   localparam logic [7:0] ADDR_OUTPUT_DRIVE_STRENGTH = 8'h26;
   localparam logic [7:0] ADDR_FORMAT_OFFSET_NOISE_SHAPING = 8'h3D;
   localparam logic [7:0] ADDR_NOISE_SHAPING_COEFFICIENT_TWO = 8'h3E;
   localparam logic [7:0] ADDR_CUSTOM_PATTERN_HIGH = 8'h3F;
   localparam logic [7:0] ADDR_CUSTOM_PATTERN_LOW = 8'h40;
   localparam logic [7:0] ADDR_INTERFACE_AND_CLOCK_RISE_CONTROL = 8'h41;
   localparam logic [7:0] ADDR_CLOCK_FALL_LATENCY_STANDBY = 8'h42;
   localparam logic [7:0] ADDR_POWER_DOWN_AND_SWING_ENABLE = 8'h43;
   localparam logic [7:0] ADDR_OFFSET_ADD_VALUE = 8'hBF;
   localparam logic [7:0] ADDR_OFFSET_CORRECTION_CONTROL = 8'hCF;
   localparam logic [7:0] ADDR_LOW_SPEED_MODE = 8'hDF;
   localparam logic [7:0] ADDR_NOISE_SHAPING_PIN_OVERRIDE = 8'hEA;
   // index order of the storage array
   localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
      ADDR_RESET_AND_READBACK_CONTROL, ADDR_OUTPUT_SWING_SELECT,
      ADDR_GAIN_AND_TEST_PATTERN, ADDR_OUTPUT_DRIVE_STRENGTH,
      ADDR_FORMAT_OFFSET_NOISE_SHAPING, ADDR_NOISE_SHAPING_COEFFICIENT_TWO,
      ADDR_CUSTOM_PATTERN_HIGH, ADDR_CUSTOM_PATTERN_LOW,
      ADDR_INTERFACE_AND_CLOCK_RISE_CONTROL, ADDR_CLOCK_FALL_LATENCY_STANDBY,
      ADDR_POWER_DOWN_AND_SWING_ENABLE, ADDR_OFFSET_ADD_VALUE,
      ADDR_OFFSET_CORRECTION_CONTROL, ADDR_LOW_SPEED_MODE,
      ADDR_NOISE_SHAPING_PIN_OVERRIDE};
   // writable bits per register, reserved bits stay zero
   localparam logic [7:0] REG_MASK [NUM_REGS] = '{
      8'h01, 8'hFC, 8'hF7, 8'h03, 8'hFF, 8'hF0, 8'hFF, 8'hE0,
      8'hFF, 8'hCD, 8'h53, 8'hE0, 8'hB8, 8'h30, 8'h80};
   localparam int IDX_CTRL = 0;
   localparam int IDX_SWING = 1;
   localparam int IDX_PWR = 10;
   localparam int READBACK_BIT = 0;
   localparam int SOFT_RESET_BIT = 1;
   localparam int SWING_LSB = 2;
   localparam int SWING_W = 6;
   localparam logic [SWING_W-1:0] SWING_DEFAULT = 6'h00;
   localparam logic [1:0] SWING_EN_OFF = 2'h0;
endpackage : cfg_bank_pkg

// *** rtl/pin_filter.sv ***
// three-stage pin synchroniser with agreement filter
// assumes pin is asynchronous to clk
`timescale 1ns/1ps
module pin_filter
#(
   parameter logic RESET_LEVEL = 1'b0
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin,
   output logic level
);
   logic s1_q, s2_q, s3_q, lvl_q;
   logic s1_d, s2_d, s3_d, lvl_d;

   always_comb
   begin
      s1_d = pin;
      s2_d = s1_q;
      s3_d = s2_q;
      // change accepted once stages two and three agree
      lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         s1_q <= RESET_LEVEL;
         s2_q <= RESET_LEVEL;
         s3_q <= RESET_LEVEL;
         lvl_q <= RESET_LEVEL;
      end
      else
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         lvl_q <= lvl_d;
      end
   end

   assign level = lvl_q;
endmodule : pin_filter

// *** tb/cfg_bank_monitor.sv ***
// port checker for the configuration register bank
// assumes one clock domain and binding to the bank's top module
`timescale 1ns/1ps
module cfg_bank_monitor
   import cfg_bank_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hw_reset,
   input wire logic sclk,
   input wire logic overrange_in,
   input wire logic overrange_or_readback_pin,
   input wire logic readback_mode,
   input wire logic [SWING_W-1:0] swing_code,
   input wire logic [10:0] custom_pattern,
   input wire logic [7:0] power_down_and_swing_enable,
   input wire logic [7:0] offset_add_value,
   input wire logic [7:0] offset_correction_control
);
   logic sclk_q;
   logic sclk_d;
   logic [3:0] quiet_q;
   logic [3:0] quiet_d;
   logic [3:0] hw_gap_q;
   logic [3:0] hw_gap_d;
   // cycles since last serial clock edge or reset pin, and since reset pin alone
   always_comb
   begin
      sclk_d = sclk;
      quiet_d = quiet_q;
      hw_gap_d = hw_gap_q;
      if (hw_reset || sclk != sclk_q)
      begin
         quiet_d = 4'h0;
      end
      else if (quiet_q != 4'hF)
      begin
         quiet_d = quiet_q + 4'h1;
      end
      if (hw_reset)
      begin
         hw_gap_d = 4'h0;
      end
      else if (hw_gap_q != 4'hF)
      begin
         hw_gap_d = hw_gap_q + 4'h1;
      end
   end
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sclk_q <= sclk;
         quiet_q <= 4'h0;
         hw_gap_q <= 4'hF;
      end
      else
      begin
         sclk_q <= sclk_d;
         quiet_q <= quiet_d;
         hw_gap_q <= hw_gap_d;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_swing_gated: assert property (power_down_and_swing_enable[1:0] == SWING_EN_OFF |->
      swing_code == SWING_DEFAULT) else $error("swing code passed while disabled");
   a_regs_hold: assert property (quiet_q >= 4'hC |-> $stable(offset_add_value)
      && $stable(power_down_and_swing_enable) && $stable(readback_mode))
      else $error("register changed without serial clock edge");
   a_pattern_hold: assert property (quiet_q >= 4'hC |=> $stable(custom_pattern))
      else $error("pattern changed without serial clock edge");
   a_over_follow: assert property ($past(rst_b) && hw_gap_q >= 4'h8 && !readback_mode
      && !$past(readback_mode) |-> overrange_or_readback_pin == $past(overrange_in))
      else $error("overrange not passed");
   a_cf_reserved: assert property ((offset_correction_control & 8'h47) == 8'h00)
      else $error("reserved bits of offset control set");
   a_pwr_reserved: assert property ((power_down_and_swing_enable & ~REG_MASK[IDX_PWR])
      == 8'h00) else $error("reserved bits of power register set");
   a_hw_clear: assert property (hw_reset [*8] |-> offset_add_value == 8'h00
      && custom_pattern == 11'h000 && !readback_mode) else $error("reset pin did not clear");
   a_rst_clear: assert property ($rose(rst_b) |-> offset_add_value == 8'h00
      && !readback_mode && !overrange_or_readback_pin) else $error("reset did not clear");
   a_readback_lock: assert property (readback_mode && $past(readback_mode)
      |-> $stable(offset_add_value) && $stable(custom_pattern)) else $error("write in readback");
endmodule : cfg_bank_monitor
bind adc_config_register_bank cfg_bank_monitor i_cfg_bank_monitor (.*);

// *** tb/serial_ctrl_model.sv ***
// serial controller model driving the three-wire port
// assumes clk is the bench clock; serial clock phases span 8 clk
`timescale 1ns/1ps
module serial_ctrl_model
(
   input wire logic clk,
   input wire logic overrange_or_readback_pin,
   output logic sclk,
   output logic serial_select_n,
   output logic serial_data_in
);
   initial
   begin
      sclk = 1'b1;
      serial_select_n = 1'b1;
      serial_data_in = 1'b0;
   end
   // n falls of one word, msb first, readback sampled before each of the eight data-bit falls
   task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
      rd = 8'h00;
      serial_select_n = 1'b0;
      for (int i = 15; i > 15 - n; i--)
      begin
         serial_data_in = w[i];
         repeat (8) @(negedge clk);
         if (i < 8) rd[i] = overrange_or_readback_pin;
         sclk = 1'b0;
         repeat (8) @(negedge clk);
         sclk = 1'b1;
      end
   endtask : xfer
   task automatic close_frame();
      repeat (8) @(negedge clk);
      serial_select_n = 1'b1;
      serial_data_in = ~serial_data_in;
      repeat (8) @(negedge clk);
   endtask : close_frame
endmodule : serial_ctrl_model

// *** tb/tb.sv ***
// self-checking bench for the configuration register bank
// assumes the controller model drives all serial pins
`timescale 1ns/1ps
module tb;
   import cfg_bank_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hw_reset = 1'b0;
   logic overrange_in = 1'b0;
   logic sclk, serial_select_n, serial_data_in, pin, readback_mode;
   logic [5:0] swing_code;
   logic [10:0] custom_pattern;
   logic [7:0] ods, icr, pds, opd, occ, lsm, rd;
   logic [7:0] gtp, fon, nc2, cfl, npo;
   logic [5:0] codes [6] = '{6'h00, 6'h1B, 6'h32, 6'h14, 6'h3E, 6'h0F};
   int err_total = 0;
   int comparisons = 0;
   always #25 clk = ~clk;
   serial_ctrl_model i_serial_ctrl_model (.clk(clk), .overrange_or_readback_pin(pin),
      .sclk(sclk), .serial_select_n(serial_select_n), .serial_data_in(serial_data_in));
   adc_config_register_bank i_adc_config_register_bank (.clk(clk), .rst_b(rst_b),
      .hw_reset(hw_reset), .sclk(sclk), .serial_select_n(serial_select_n),
      .serial_data_in(serial_data_in), .overrange_in(overrange_in),
      .overrange_or_readback_pin(pin), .readback_mode(readback_mode),
      .swing_code(swing_code), .custom_pattern(custom_pattern), .gain_and_test_pattern(gtp),
      .output_drive_strength(ods), .format_offset_noise_shaping(fon),
      .noise_shaping_coefficient_two(nc2), .interface_and_clock_rise_control(icr),
      .clock_fall_latency_standby(cfl), .power_down_and_swing_enable(pds),
      .offset_add_value(opd), .offset_correction_control(occ), .low_speed_mode(lsm),
      .noise_shaping_pin_override(npo));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_serial_ctrl_model.xfer({a, d}, 16, rd);
      i_serial_ctrl_model.close_frame();
   endtask : wr
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   initial
   begin
      #2000000;
      err_total++;
      end_sim();
   end
   initial
   begin
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      repeat (8) @(negedge clk);
      chk("pds", pds, 8'h00);
      wr(8'h01, 8'h6C);
      chk("swing off", swing_code, 6'h00);
      wr(8'h43, 8'h03);
      chk("swing on", swing_code, 6'h1B);
      foreach (codes[k])
      begin
         wr(8'h01, {codes[k], 2'b00});
         chk("swing", swing_code, codes[k]);
      end
      $display("test swing done");
      i_serial_ctrl_model.xfer(16'h3FA5, 16, rd);
      i_serial_ctrl_model.xfer(16'h40E0, 16, rd);
      i_serial_ctrl_model.xfer(16'h3F00, 5, rd);
      i_serial_ctrl_model.close_frame();
      chk("pattern", custom_pattern, 11'h52F);
      wr(8'h41, 8'hA6);
      chk("icr", icr, 8'hA6);
      wr(8'hCF, 8'hB8);
      chk("occ", occ, 8'hB8);
      wr(8'h25, 8'h75);
      chk("gtp", gtp, 8'h75);
      wr(8'h3D, 8'hA3);
      chk("fon", fon, 8'hA3);
      wr(8'h3E, 8'h90);
      chk("nc2", nc2, 8'h90);
      wr(8'h42, 8'hC5);
      chk("cfl", cfl, 8'hC5);
      wr(8'hEA, 8'h80);
      chk("npo", npo, 8'h80);
      $display("test fields done");
      overrange_in = 1'b1;
      repeat (3) @(negedge clk);
      chk("ovr", pin, 1'b1);
      wr(8'h00, 8'h01);
      chk("rb mode", readback_mode, 1'b1);
      wr(8'hCF, 8'h00);
      chk("read cf", rd, 8'hB8);
      chk("occ kept", occ, 8'hB8);
      wr(8'h42, 8'h00);
      chk("read 42", rd, 8'hC5);
      chk("cfl kept", cfl, 8'hC5);
      wr(8'hBF, 8'hE0);
      chk("opd", opd, 8'h00);
      wr(8'h00, 8'h00);
      chk("read 00", rd, 8'h00);
      chk("rb off", readback_mode, 1'b0);
      $display("test readback done");
      wr(8'h26, 8'h03);
      wr(8'h00, 8'h02);
      chk("ods", ods, 8'h00);
      chk("icr", icr, 8'h00);
      chk("swing rst", swing_code, 6'h00);
      wr(8'h26, 8'h01);
      chk("ods", ods, 8'h01);
      wr(8'hDF, 8'h30);
      wr(8'hBF, 8'hE0);
      chk("opd", opd, 8'hE0);
      hw_reset = 1'b1;
      repeat (10) @(negedge clk);
      hw_reset = 1'b0;
      repeat (8) @(negedge clk);
      chk("lsm", lsm, 8'h00);
      chk("opd hw", opd, 8'h00);
      wr(8'hBF, 8'hE0);
      rst_b = 1'b0;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      repeat (8) @(negedge clk);
      chk("opd rst", opd, 8'h00);
      chk("ovr rst", pin, 1'b1);
      $display("test resets done");
      end_sim();
   end
endmodule : tb
